// ### clrr_regs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "clrr_regs.vh"
module clrr_regs_top (
  input wire clk_in,
  input wire rst_n_in,
  input wire wr_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  output wire hit_out,
  input wire discharge_mode_in,
  input wire input_regulation_scale_sel_in,
  output reg [7:0] battery_current_limit_code_out,
  output reg [3:0] battery_current_scale_out,
  output reg [8:0] battery_limit_numerator_out,
  output reg battery_limit_active_out,
  output reg [15:0] input_regulation_voltage_out,
  output reg input_regulation_active_out,
  output reg [3:0] bus_current_scale_out,
  output reg bus_scale_illegal_out,
  output reg [7:0] battery_monitor_tenths_out,
  output reg [7:0] bus_voltage_tenths_out
);

  // ********************************************************
  // Storage
  // ********************************************************
  // Host-visible copies of the three registers
  reg [7:0] batlim_reg;
  reg [7:0] inreg_reg;
  reg [7:0] ratio_reg;
  // Next register contents and next read data
  reg [7:0] batlim_next;
  reg [7:0] inreg_next;
  reg [7:0] ratio_next;
  reg [7:0] rdata_next;
  // Offset decode, one strobe per register
  wire sel_batlim;
  wire sel_inreg;
  wire sel_ratio;
  // Derived values, registered into the outputs below
  reg [8:0] numerator_next;
  reg [3:0] bat_scale_next;
  reg [15:0] inreg_mv_next;
  reg [3:0] bus_scale_next;
  reg bus_illegal_next;
  reg [7:0] bat_mon_next;
  reg [7:0] bus_v_next;

  // Ratio bit to tenths factor, shared by battery and bus
  function [7:0] ratio_tenths;
    input sel;
    begin
      ratio_tenths = sel ? `CLRR_TENTHS_5 : `CLRR_TENTHS_125;
    end
  endfunction

  // Offset compare, shared by the hit flag, writes and reads
  function offset_match;
    input [7:0] addr;
    input [7:0] offset;
    begin
      offset_match = (addr == offset);
    end
  endfunction

  // ********************************************************
  // Register port
  // ********************************************************
  // Decode is purely combinational; reads need no strobe
  assign sel_batlim = offset_match(addr_in, `CLRR_OFS_BATLIM);
  assign sel_inreg = offset_match(addr_in, `CLRR_OFS_INREG);
  assign sel_ratio = offset_match(addr_in, `CLRR_OFS_RATIO);
  assign hit_out = sel_batlim || sel_inreg || sel_ratio;

  // Next register contents; unmapped writes fall through untouched
  always @* begin
    batlim_next = batlim_reg;
    inreg_next = inreg_reg;
    ratio_next = ratio_reg;
    if (wr_en_in) begin
      if (sel_batlim) begin
        batlim_next = wdata_in;
      end
      if (sel_inreg) begin
        inreg_next = wdata_in;
      end
      // Reserved ratio bits are stored as written; the host keeps them
      if (sel_ratio) begin
        ratio_next = wdata_in;
      end
    end
  end

  // Register update; power-on values come from the header
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      batlim_reg <= `CLRR_RST_BATLIM;
      inreg_reg <= `CLRR_RST_INREG;
      ratio_reg <= `CLRR_RST_RATIO;
    end else begin
      batlim_reg <= batlim_next;
      inreg_reg <= inreg_next;
      ratio_reg <= ratio_next;
    end
  end

  // Read mux; unmapped offsets read zero so a stray read is harmless
  always @* begin
    rdata_next = 8'h00;
    if (sel_batlim) begin
      rdata_next = batlim_reg;
    end else if (sel_inreg) begin
      rdata_next = inreg_reg;
    end else if (sel_ratio) begin
      rdata_next = ratio_reg;
    end
  end

  // Read data is registered, so it lags the address by one clock
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_next;
    end
  end

  // ********************************************************
  // Decoded settings for the regulation loops
  // ********************************************************
  // Battery current limit: numerator of (code + 1) / 256
  always @* begin
    numerator_next = {1'b0, batlim_reg} + 9'h001;
    bat_scale_next = `CLRR_MUL_BAT_LO;
    if (ratio_reg[`CLRR_BIT_BATSCL]) begin
      bat_scale_next = `CLRR_MUL_BAT_HI;
    end
  end

  // Input regulation in millivolts; 256 x 100 still fits 16 bits
  // Scale select lives in a later register, so it arrives as a pin
  always @* begin
    if (input_regulation_scale_sel_in) begin
      inreg_mv_next = ({8'h00, inreg_reg} + 16'h0001) *
        {8'h00, `CLRR_MUL_INREG_LO};
    end else begin
      inreg_mv_next = ({8'h00, inreg_reg} + 16'h0001) *
        {8'h00, `CLRR_MUL_INREG_HI};
    end
  end

  // Bus current scale; forbidden codes fall back to the smallest scale
  always @* begin
    case (ratio_reg[`CLRR_BIT_BUSSCL_HI:`CLRR_BIT_BUSSCL_LO])
      2'h1: begin
        bus_scale_next = `CLRR_MUL_BUS_01;
        bus_illegal_next = 1'b0;
      end
      2'h2: begin
        bus_scale_next = `CLRR_MUL_BUS_10;
        bus_illegal_next = 1'b0;
      end
      default: begin
        // Flag the code so firmware can spot a bad write
        bus_scale_next = `CLRR_MUL_BUS_10;
        bus_illegal_next = 1'b1;
      end
    endcase
  end

  // Voltage ratios in tenths; the bus ratio serves setting and monitor
  always @* begin
    bat_mon_next = ratio_tenths(ratio_reg[`CLRR_BIT_BATMON]);
    bus_v_next = ratio_tenths(ratio_reg[`CLRR_BIT_BUSV]);
  end

  // ********************************************************
  // Output stage
  // ********************************************************
  // Battery current limit outputs, one clock after the register
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      battery_current_limit_code_out <= `CLRR_RST_BATLIM;
      battery_limit_numerator_out <= 9'h100;
      battery_current_scale_out <= `CLRR_MUL_BAT_HI;
      battery_limit_active_out <= 1'b0;
    end else begin
      battery_current_limit_code_out <= batlim_reg;
      battery_limit_numerator_out <= numerator_next;
      // Limit holds regardless of direction, so no mode gating here
      battery_limit_active_out <= 1'b1;
      battery_current_scale_out <= bat_scale_next;
    end
  end

  // Input regulation outputs
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_regulation_voltage_out <= 16'h0000;
      input_regulation_active_out <= 1'b0;
    end else begin
      input_regulation_voltage_out <= inreg_mv_next;
      // Discharging leaves the input regulation reference unused
      input_regulation_active_out <= !discharge_mode_in;
    end
  end

  // Ratio outputs
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_current_scale_out <= `CLRR_MUL_BUS_10;
      bus_scale_illegal_out <= 1'b0;
      battery_monitor_tenths_out <= `CLRR_TENTHS_125;
      bus_voltage_tenths_out <= `CLRR_TENTHS_125;
    end else begin
      bus_current_scale_out <= bus_scale_next;
      bus_scale_illegal_out <= bus_illegal_next;
      battery_monitor_tenths_out <= bat_mon_next;
      bus_voltage_tenths_out <= bus_v_next;
    end
  end

endmodule
`default_nettype wire

// ### clrr_regs.vh
`ifndef CLRR_REGS_VH
`define CLRR_REGS_VH
// Register offsets
`define CLRR_OFS_BATLIM 8'h06
`define CLRR_OFS_INREG 8'h07
`define CLRR_OFS_RATIO 8'h08
// Reset values
`define CLRR_RST_BATLIM 8'hFF
`define CLRR_RST_INREG 8'h2C
`define CLRR_RST_RATIO 8'h38
// Ratio register fields
`define CLRR_BIT_BATSCL 4
`define CLRR_BIT_BUSSCL_HI 3
`define CLRR_BIT_BUSSCL_LO 2
`define CLRR_BIT_BATMON 1
`define CLRR_BIT_BUSV 0
// Scale multipliers
`define CLRR_MUL_INREG_LO 8'h28
`define CLRR_MUL_INREG_HI 8'h64
`define CLRR_MUL_BAT_LO 4'h6
`define CLRR_MUL_BAT_HI 4'hC
`define CLRR_MUL_BUS_01 4'h6
`define CLRR_MUL_BUS_10 4'h3
// Ratio factors in tenths: 12.5 and 5
`define CLRR_TENTHS_125 8'h7D
`define CLRR_TENTHS_5 8'h32
`endif

// ### clrr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the register port; stale write data is inverted on release
module clrr_host (
  input wire clk_in,
  input wire [7:0] rdata_out,
  output logic wr_en_in = 1'b0,
  output logic [7:0] addr_in = 8'h00, wdata_in = 8'h00
);
  // Strobe for one edge, then wait until readback and outputs settle
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk_in);
    wr_en_in <= w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    wdata_in <= ~d;
    @(posedge clk_in) #1;
  endtask
  // Battery voltage in mV from the two converter readings and ratio
  function automatic logic [15:0] vbat_mv(input logic [7:0] hi,
    input logic [1:0] lo, input logic [7:0] tenths);
    int steps;
    steps = 4 * hi + lo + 1;
    return 16'(steps * tenths * 2 / 10);
  endfunction
endmodule
`default_nettype wire

// ### clrr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Windows span the register to derived output latency
module clrr_regs_monitor (
  input wire clk_in, rst_n_in, wr_en_in, discharge_mode_in,
  input wire input_regulation_scale_sel_in, battery_limit_active_out,
  input wire input_regulation_active_out, bus_scale_illegal_out,
  input wire [7:0] addr_in, rdata_out, battery_current_limit_code_out,
  input wire [7:0] battery_monitor_tenths_out, bus_voltage_tenths_out,
  input wire [3:0] battery_current_scale_out, bus_current_scale_out,
  input wire [8:0] battery_limit_numerator_out,
  input wire [15:0] input_regulation_voltage_out);
  default clocking @(posedge clk_in); endclocking
  // Outputs lag reset release by one clock; skip the settling edges
  logic [1:0] warm;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) warm <= 2'h0;
    else if (warm != 2'h3) warm <= warm + 2'h1;
  end
  default disable iff (!rst_n_in || warm != 2'h3);
  sequence rd_ratio; (!wr_en_in && addr_in == 8'h08) [*2]; endsequence
  sequence rd_limit; (!wr_en_in && addr_in == 8'h06) [*2]; endsequence
  chk_lim_num: assert property (rd_limit |->
    battery_limit_numerator_out == rdata_out + 9'h1 &&
    battery_current_limit_code_out == rdata_out) else $error("numerator");
  chk_mode_dis: assert property (discharge_mode_in [*2] |->
    battery_limit_active_out && !input_regulation_active_out) else $error("dis");
  chk_mode_chg: assert property (!discharge_mode_in [*2] |->
    input_regulation_active_out) else $error("chg");
  chk_inreg_mv: assert property ((!wr_en_in && addr_in == 8'h07 &&
    $stable(input_regulation_scale_sel_in)) [*2] |-> input_regulation_voltage_out
    == (rdata_out + 16'h1) * (input_regulation_scale_sel_in ? 16'h28 : 16'h64))
    else $error("mv");
  chk_bat_scl: assert property (rd_ratio |->
    battery_current_scale_out == (rdata_out[4] ? 4'hC : 4'h6)) else $error("bat");
  chk_mon_rat: assert property (rd_ratio |->
    battery_monitor_tenths_out == (rdata_out[1] ? 8'h32 : 8'h7D)) else $error("mon");
  chk_busv_rat: assert property (rd_ratio |->
    bus_voltage_tenths_out == (rdata_out[0] ? 8'h32 : 8'h7D)) else $error("busv");
  chk_bus_scl: assert property (rd_ratio |->
    bus_current_scale_out == (rdata_out[3:2] == 2'b01 ? 4'h6 : 4'h3) &&
    bus_scale_illegal_out == (rdata_out[3] == rdata_out[2])) else $error("bus");
endmodule
bind clrr_regs_top clrr_regs_monitor u_clrr_regs_monitor (.*);
`default_nettype wire

// ### clrr_regs_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module clrr_regs_top_test;
  logic clk_in = 1'b0, rst_n_in = 1'b0, discharge_mode_in = 1'b0;
  logic input_regulation_scale_sel_in = 1'b0;
  wire wr_en_in, hit_out, battery_limit_active_out, bus_scale_illegal_out;
  wire input_regulation_active_out;
  wire [7:0] addr_in, wdata_in, rdata_out, battery_current_limit_code_out;
  wire [7:0] battery_monitor_tenths_out, bus_voltage_tenths_out;
  wire [3:0] battery_current_scale_out, bus_current_scale_out;
  wire [8:0] battery_limit_numerator_out;
  wire [15:0] input_regulation_voltage_out;
  logic [7:0] rst_vals [3] = '{8'hFF, 8'h2C, 8'h38};
  // First value sets the 5x monitor ratio for a low-cell pack
  logic [7:0] vals [4] = '{8'h2F, 8'h24, 8'h30, 8'h38};
  int n_fail = 0, checked = 0, cyc = 0;
  clrr_regs_top u_clrr_regs_top (.*);
  clrr_host u_clrr_host (.*);
  always #20 clk_in = ~clk_in;
  // Hang guard, far past the roughly 60 cycles needed
  always @(posedge clk_in) if (++cyc == 2000) results(1);
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("Error %0t: got %h want %h", $time, got, exp);
  endtask
  task automatic results(input int late);
    n_fail += late;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Power-on contents, then code boundaries and both input scales
  task automatic t_limits;
    foreach (rst_vals[i]) begin
      u_clrr_host.acc(1'b0, 8'h06 + 8'(i), 8'h00);
      chk(rdata_out, rst_vals[i]);
      chk(hit_out, 1'b1);
    end
    u_clrr_host.acc(1'b1, 8'h06, 8'h00);
    chk(battery_limit_numerator_out, 9'h001);
    // A write to an unmapped offset must leave the limit alone
    u_clrr_host.acc(1'b1, 8'h09, 8'h55);
    chk(hit_out, 1'b0);
    chk(rdata_out, 8'h00);
    chk(battery_current_limit_code_out, 8'h00);
    u_clrr_host.acc(1'b1, 8'h07, 8'hFF);
    chk(input_regulation_voltage_out, 16'h6400);
    @(posedge clk_in) input_regulation_scale_sel_in <= 1'b1;
    u_clrr_host.acc(1'b0, 8'h07, 8'h00);
    chk(input_regulation_voltage_out, 16'h2800);
  endtask
  // Every ratio field; reserved bits written back as read
  task automatic t_ratio(input logic [7:0] v);
    logic [15:0] mv;
    u_clrr_host.acc(1'b1, 8'h08, v);
    chk(rdata_out, v);
    chk(battery_current_scale_out, v[4] ? 4'hC : 4'h6);
    chk(bus_current_scale_out, v[3:2] == 2'b01 ? 4'h6 : 4'h3);
    chk(bus_scale_illegal_out, v[3] == v[2]);
    chk(battery_monitor_tenths_out, v[1] ? 8'h32 : 8'h7D);
    chk(bus_voltage_tenths_out, v[0] ? 8'h32 : 8'h7D);
    mv = u_clrr_host.vbat_mv(8'h9F, 2'h3, battery_monitor_tenths_out);
    chk(mv, v[1] ? 16'h1900 : 16'h3E80);
  endtask
  // Discharging keeps the current limit, drops input regulation
  task automatic t_modes;
    @(posedge clk_in) discharge_mode_in <= 1'b1;
    u_clrr_host.acc(1'b0, 8'h06, 8'h00);
    chk(battery_limit_active_out, 1'b1);
    chk(input_regulation_active_out, 1'b0);
    @(posedge clk_in) discharge_mode_in <= 1'b0;
    u_clrr_host.acc(1'b0, 8'h06, 8'h00);
    chk(battery_limit_active_out, 1'b1);
    chk(input_regulation_active_out, 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_limits;
    foreach (vals[i]) t_ratio(vals[i]);
    t_modes;
    results(0);
  end
endmodule
`default_nettype wire
